/* File: rtl/imdc_pkg.sv */
// package: register map, field positions and reset values of the mask and config bank
package imdc_pkg;
  // register byte addresses (printed offsets are indices, not all multiples of four)
  localparam logic [7:0]  IDX_DATA_PATH_CONFIG   = 8'h0e;
  localparam logic [7:0]  IDX_INTERRUPT_ENABLE   = 8'h0f;
  localparam logic [11:0] ADDR_DATA_PATH_CONFIG  = {2'b00, IDX_DATA_PATH_CONFIG, 2'b00};
  localparam logic [11:0] ADDR_INTERRUPT_ENABLE  = {2'b00, IDX_INTERRUPT_ENABLE, 2'b00};
  localparam logic [11:0] ADDR_CAUSE_FLAGS       = 12'h0100;
  localparam logic [11:0] ADDR_DMA_VIEW          = 12'h0104;
  // interrupt cause bit positions
  localparam int BIT_RX_OK        = 0;
  localparam int BIT_TX_OK        = 1;
  localparam int BIT_RX_ERR       = 2;
  localparam int BIT_TX_ERR       = 3;
  localparam int BIT_RING_FULL    = 4;
  localparam int BIT_TALLY_OVF    = 5;
  localparam int BIT_HOST_XFER    = 6;
  localparam int BIT_RESERVED     = 7;
  // config field positions
  localparam int BIT_WORD_WIDTH   = 0;
  localparam int BIT_LANE_ORDER   = 1;
  localparam int BIT_WIDE_ADDR    = 2;
  // reset values and masks
  localparam logic [7:0]  MASK_RESET       = 8'h00;
  localparam logic [7:0]  CONFIG_RESET     = 8'h04;
  localparam logic [7:0]  CAUSE_VALID      = 8'h7f;
  localparam logic [31:0] ZERO_WORD        = 32'h0000_0000;
endpackage : imdc_pkg

/* File: rtl/imdc_lane_mux.sv */
// byte lane steering of the 16-bit data path under the config bits
`timescale 1ns/10ps
`default_nettype none
module imdc_lane_mux (
  input  wire logic        word_mode,   // word-wide transfers selected
  input  wire logic        lane_swap,   // lane order swap requested
  input  wire logic [15:0] data_in,     // ms byte in [15:8]
  output var  logic [15:0] data_out     // bus lanes
);
  always_comb begin
    if (word_mode && lane_swap) begin
      data_out = {data_in[7:0], data_in[15:8]};
    end else begin
      data_out = data_in;
    end
  end
endmodule : imdc_lane_mux
`default_nettype wire

/* File: rtl/imdc_top.sv */
// interrupt enable mask and data path config bank with APB slave
//
// Added by the designer: register access over APB.
`timescale 1ns/10ps
`default_nettype none
module imdc_top #(
  parameter int ADDR_W = 16                    // dma address width per channel
) (
  input  wire logic        CLK,                // 200 MHz clock
  input  wire logic        RST,                // async reset, active high
  input  wire logic        PSEL,               // apb select
  input  wire logic        PENABLE,            // apb access phase
  input  wire logic        PWRITE,             // apb direction
  input  wire logic [11:0] PADDR,              // apb byte address
  input  wire logic [31:0] PWDATA,             // apb write data
  output logic      [31:0] PRDATA,             // apb read data
  output logic             PREADY,             // apb ready
  output logic             PSLVERR,            // apb error
  input  wire logic [7:0]  CAUSE_FLAGS,        // interrupt_cause_flags from status
  input  wire logic [15:0] HOST_XFER_ADDR,     // host_xfer_start_addr contents
  input  wire logic [15:0] DMA_ADDR,           // dma byte/word address from engine
  input  wire logic [15:0] DMA_DATA,           // dma data, ms byte in [15:8]
  output logic             IRQ,                // interrupt, active high level
  output logic             WORD_WIDTH_SEL,     // word_width_sel
  output logic             LANE_ORDER_SEL,     // lane_order_sel
  output logic             WIDE_ADDR_SEL,      // wide_addr_sel
  output logic [15:0]      ADDR_LOW,           // dma address lines A0-A15
  output logic [15:0]      ADDR_HIGH,          // upper address lines A16-A31
  output logic [15:0]      DATA_LANES          // lane steered data AD15-AD0
);
  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [7:0]  interrupt_enable_mask;
  logic [7:0]  data_path_config;
  logic [15:0] lanes;
  logic        wr_en;
  logic        rd_en;
  logic        next_irq;

  function automatic logic hit(input logic [11:0] a);
    hit = (a == imdc_pkg::ADDR_DATA_PATH_CONFIG) || (a == imdc_pkg::ADDR_INTERRUPT_ENABLE)
       || (a == imdc_pkg::ADDR_CAUSE_FLAGS) || (a == imdc_pkg::ADDR_DMA_VIEW);
  endfunction : hit

  // access is taken in the first access cycle: pready rises the cycle after penable, one wait state per access
  assign wr_en = PSEL && PENABLE && PWRITE && !PREADY;
  assign rd_en = PSEL && PENABLE && !PWRITE && !PREADY;

  // ------------------------------------------------------------
  // apb handshake
  // ------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= PSEL && PENABLE && !PREADY;
      PSLVERR <= PSEL && PENABLE && !PREADY && !hit(PADDR);
    end
  end

  // ------------------------------------------------------------
  // mask register
  // ------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      interrupt_enable_mask <= imdc_pkg::MASK_RESET;
    end else if (wr_en && PADDR == imdc_pkg::ADDR_INTERRUPT_ENABLE) begin
      // reserved bit stored for readback only, never gates anything
      interrupt_enable_mask <= PWDATA[7:0];
    end
  end

  // ------------------------------------------------------------
  // data path config; the host orders this before byte counts
  // ------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      data_path_config <= imdc_pkg::CONFIG_RESET;
    end else if (wr_en && PADDR == imdc_pkg::ADDR_DATA_PATH_CONFIG) begin
      data_path_config <= PWDATA[7:0];
    end
  end

  // ------------------------------------------------------------
  // read data; write-only registers are readable for diagnosis
  // ------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PRDATA <= imdc_pkg::ZERO_WORD;
    end else if (rd_en) begin
      case (PADDR)
        imdc_pkg::ADDR_INTERRUPT_ENABLE: PRDATA <= {24'h00_0000, interrupt_enable_mask};
        imdc_pkg::ADDR_DATA_PATH_CONFIG: PRDATA <= {24'h00_0000, data_path_config};
        imdc_pkg::ADDR_CAUSE_FLAGS:      PRDATA <= {23'h00_0000, IRQ, CAUSE_FLAGS};
        imdc_pkg::ADDR_DMA_VIEW:         PRDATA <= {ADDR_HIGH, ADDR_LOW};
        default:                         PRDATA <= imdc_pkg::ZERO_WORD;
      endcase
    end
  end

  // ------------------------------------------------------------
  // interrupt gating
  // ------------------------------------------------------------
  always_comb begin
    // bits 0..6 each gate the cause at the same position; bit 7 excluded
    next_irq = |(CAUSE_FLAGS & interrupt_enable_mask & imdc_pkg::CAUSE_VALID);
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= next_irq;
    end
  end

  // ------------------------------------------------------------
  // dma steering outputs
  // ------------------------------------------------------------
  imdc_lane_mux u_lane (
    .word_mode (data_path_config[imdc_pkg::BIT_WORD_WIDTH]),
    .lane_swap (data_path_config[imdc_pkg::BIT_LANE_ORDER]),
    .data_in   (DMA_DATA),
    .data_out  (lanes)
  );

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      WORD_WIDTH_SEL <= 1'b0;
      LANE_ORDER_SEL <= 1'b0;
      WIDE_ADDR_SEL  <= 1'b1;
      ADDR_LOW       <= 16'h0000;
      ADDR_HIGH      <= 16'h0000;
      DATA_LANES     <= 16'h0000;
    end else begin
      WORD_WIDTH_SEL <= data_path_config[imdc_pkg::BIT_WORD_WIDTH];
      LANE_ORDER_SEL <= data_path_config[imdc_pkg::BIT_LANE_ORDER];
      WIDE_ADDR_SEL  <= data_path_config[imdc_pkg::BIT_WIDE_ADDR];
      // word mode: 32K words, bit 0 forced low
      if (data_path_config[imdc_pkg::BIT_WORD_WIDTH]) begin
        ADDR_LOW <= {DMA_ADDR[15:1], 1'b0};
      end else begin
        ADDR_LOW <= DMA_ADDR;
      end
      if (data_path_config[imdc_pkg::BIT_WIDE_ADDR]) begin
        ADDR_HIGH <= HOST_XFER_ADDR;
      end else begin
        ADDR_HIGH <= 16'h0000;
      end
      DATA_LANES <= lanes;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  property p_rx_ok_gate;
    @(posedge CLK) disable iff (RST)
      (CAUSE_FLAGS == 8'h01 && interrupt_enable_mask[0]) |=> IRQ;
  endproperty
  a_rx_ok_gate: assert property (p_rx_ok_gate) else $error("rx ok not raised");

  property p_tx_ok_gate;
    @(posedge CLK) disable iff (RST)
      (CAUSE_FLAGS == 8'h02 && !interrupt_enable_mask[1]) |=> !IRQ;
  endproperty
  a_tx_ok_gate: assert property (p_tx_ok_gate) else $error("tx ok leaked");

  property p_rx_err_gate;
    @(posedge CLK) disable iff (RST)
      (CAUSE_FLAGS == 8'h04) |=> (IRQ == $past(interrupt_enable_mask[2]));
  endproperty
  a_rx_err_gate: assert property (p_rx_err_gate) else $error("rx err gate");

  property p_tx_err_gate;
    @(posedge CLK) disable iff (RST)
      (CAUSE_FLAGS == 8'h08) |=> (IRQ == $past(interrupt_enable_mask[3]));
  endproperty
  a_tx_err_gate: assert property (p_tx_err_gate) else $error("tx err gate");

  property p_ring_gate;
    @(posedge CLK) disable iff (RST)
      (CAUSE_FLAGS == 8'h10) |=> (IRQ == $past(interrupt_enable_mask[4]));
  endproperty
  a_ring_gate: assert property (p_ring_gate) else $error("ring full gate");

  property p_tally_gate;
    @(posedge CLK) disable iff (RST)
      (CAUSE_FLAGS == 8'h20) |=> (IRQ == $past(interrupt_enable_mask[5]));
  endproperty
  a_tally_gate: assert property (p_tally_gate) else $error("tally gate");

  property p_xfer_gate;
    @(posedge CLK) disable iff (RST)
      (CAUSE_FLAGS == 8'h40) |=> (IRQ == $past(interrupt_enable_mask[6]));
  endproperty
  a_xfer_gate: assert property (p_xfer_gate) else $error("xfer done gate");

  property p_reserved;
    @(posedge CLK) disable iff (RST)
      (CAUSE_FLAGS == 8'h80) |=> !IRQ;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit raised irq");

  sequence s_cfg_write;
    wr_en && PADDR == imdc_pkg::ADDR_DATA_PATH_CONFIG;
  endsequence

  property p_width_follow;
    @(posedge CLK) disable iff (RST)
      s_cfg_write ##1 1'b1 |=>
        (WORD_WIDTH_SEL == $past(PWDATA[imdc_pkg::BIT_WORD_WIDTH], 2));
  endproperty
  a_width_follow: assert property (p_width_follow) else $error("width not applied");

  property p_word_a0;
    @(posedge CLK) disable iff (RST)
      $past(data_path_config[imdc_pkg::BIT_WORD_WIDTH]) |-> !ADDR_LOW[0];
  endproperty
  a_word_a0: assert property (p_word_a0) else $error("a0 high in word mode");

  property p_byte_no_swap;
    @(posedge CLK) disable iff (RST)
      !data_path_config[imdc_pkg::BIT_WORD_WIDTH] |=> (DATA_LANES == $past(DMA_DATA));
  endproperty
  a_byte_no_swap: assert property (p_byte_no_swap) else $error("swap in byte mode");

  property p_wide_addr;
    @(posedge CLK) disable iff (RST)
      data_path_config[imdc_pkg::BIT_WIDE_ADDR] |=> (ADDR_HIGH == $past(HOST_XFER_ADDR));
  endproperty
  a_wide_addr: assert property (p_wide_addr) else $error("upper address wrong");

  property p_irq_hold;
    @(posedge CLK) disable iff (RST)
      (|(CAUSE_FLAGS & interrupt_enable_mask & imdc_pkg::CAUSE_VALID))[*2] |-> IRQ;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped early");

  sequence s_mask_write;
    wr_en && PADDR == imdc_pkg::ADDR_INTERRUPT_ENABLE;
  endsequence

  sequence s_enabled_cause;
    |(CAUSE_FLAGS & interrupt_enable_mask & imdc_pkg::CAUSE_VALID);
  endsequence

  sequence s_reset_release;
    $fell(RST);
  endsequence

  property p_mask_reset;
    @(posedge CLK) disable iff (RST)
      s_reset_release |-> (interrupt_enable_mask == imdc_pkg::MASK_RESET);
  endproperty
  a_mask_reset: assert property (p_mask_reset) else $error("mask not clear after reset");

  property p_irq_reset;
    @(posedge CLK) disable iff (RST)
      s_reset_release |-> !IRQ;
  endproperty
  a_irq_reset: assert property (p_irq_reset) else $error("irq high after reset");

  property p_cfg_reset;
    @(posedge CLK) disable iff (RST)
      s_reset_release |-> (data_path_config == imdc_pkg::CONFIG_RESET);
  endproperty
  a_cfg_reset: assert property (p_cfg_reset) else $error("config wrong after reset");

  property p_wide_reset;
    @(posedge CLK) disable iff (RST)
      s_reset_release |-> WIDE_ADDR_SEL;
  endproperty
  a_wide_reset: assert property (p_wide_reset) else $error("wide select low after reset");

  property p_mask_write;
    @(posedge CLK) disable iff (RST)
      s_mask_write |=> (interrupt_enable_mask == $past(PWDATA[7:0]));
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write not stored");

  property p_lane_follow;
    @(posedge CLK) disable iff (RST)
      s_cfg_write ##1 1'b1 |=>
        (LANE_ORDER_SEL == $past(PWDATA[imdc_pkg::BIT_LANE_ORDER], 2));
  endproperty
  a_lane_follow: assert property (p_lane_follow) else $error("lane order not applied");

  property p_wide_follow;
    @(posedge CLK) disable iff (RST)
      s_cfg_write ##1 1'b1 |=>
        (WIDE_ADDR_SEL == $past(PWDATA[imdc_pkg::BIT_WIDE_ADDR], 2));
  endproperty
  a_wide_follow: assert property (p_wide_follow) else $error("wide select not applied");

  property p_word_swap;
    @(posedge CLK) disable iff (RST)
      data_path_config[imdc_pkg::BIT_WORD_WIDTH] && data_path_config[imdc_pkg::BIT_LANE_ORDER]
        |=> (DATA_LANES == {$past(DMA_DATA[7:0]), $past(DMA_DATA[15:8])});
  endproperty
  a_word_swap: assert property (p_word_swap) else $error("lanes not swapped");

  property p_word_straight;
    @(posedge CLK) disable iff (RST)
      data_path_config[imdc_pkg::BIT_WORD_WIDTH] && !data_path_config[imdc_pkg::BIT_LANE_ORDER]
        |=> (DATA_LANES == $past(DMA_DATA));
  endproperty
  a_word_straight: assert property (p_word_straight) else $error("lanes swapped");

  property p_byte_addr;
    @(posedge CLK) disable iff (RST)
      !data_path_config[imdc_pkg::BIT_WORD_WIDTH] |=> (ADDR_LOW == $past(DMA_ADDR));
  endproperty
  a_byte_addr: assert property (p_byte_addr) else $error("byte address altered");

  property p_word_addr;
    @(posedge CLK) disable iff (RST)
      data_path_config[imdc_pkg::BIT_WORD_WIDTH] |=> (ADDR_LOW[15:1] == $past(DMA_ADDR[15:1]));
  endproperty
  a_word_addr: assert property (p_word_addr) else $error("word address altered");

  property p_dual_addr;
    @(posedge CLK) disable iff (RST)
      !data_path_config[imdc_pkg::BIT_WIDE_ADDR] |=> (ADDR_HIGH == 16'h0000);
  endproperty
  a_dual_addr: assert property (p_dual_addr) else $error("upper address in dual mode");

  property p_irq_raise;
    @(posedge CLK) disable iff (RST)
      s_enabled_cause |=> IRQ;
  endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("enabled cause gave no irq");

  property p_irq_clear;
    @(posedge CLK) disable iff (RST)
      !(|(CAUSE_FLAGS & interrupt_enable_mask & imdc_pkg::CAUSE_VALID)) |=> !IRQ;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("irq without enabled cause");
endmodule : imdc_top
`default_nettype wire

/* File: dv/imdc_host.sv */
// host processor model: apb master for the mask and config bank
`timescale 1ns/10ps
`default_nettype none
module imdc_host (
  input  wire logic        clk,      // bus clock
  output var  logic        psel,     // select
  output var  logic        penable,  // access phase
  output var  logic        pwrite,   // direction
  output var  logic [11:0] paddr,    // byte address
  output var  logic [31:0] pwdata,   // write data
  input  wire logic [31:0] prdata,   // read data
  input  wire logic        pready,   // ready
  input  wire logic        pslverr   // error
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end

  // one transfer, held until pready; callers write config before any byte count
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err, output logic ok);
    ok = 1'b0;
    rd = 32'h0000_0000;
    err = 1'b0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    for (int n = 0; n < 50 && !ok; n++) begin
      @(posedge clk);
      if (pready === 1'b1) begin
        ok = 1'b1;
        rd = prdata;
        err = pslverr;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines must not keep showing the old values
    paddr <= ~a;
    pwdata <= ~wd;
  endtask : xfer
endmodule : imdc_host
`default_nettype wire

/* File: dv/tb_top.sv */
// self-checking bench for the mask and config bank
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam logic [11:0] A_CFG  = imdc_pkg::ADDR_DATA_PATH_CONFIG;
  localparam logic [11:0] A_MASK = imdc_pkg::ADDR_INTERRUPT_ENABLE;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  flags = 8'h7f;
  logic [15:0] hxa = 16'hbeef;
  logic [15:0] dma_addr = 16'h1235;
  logic [15:0] dma_data = 16'ha55a;
  logic        irq, word_sel, lane_sel, wide_sel;
  logic [15:0] addr_low, addr_high, lanes;
  int          n_mismatch = 0;
  int          cmp_count = 0;

  always #2.5 clk = ~clk;

  imdc_top i_dut (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CAUSE_FLAGS(flags), .HOST_XFER_ADDR(hxa), .DMA_ADDR(dma_addr), .DMA_DATA(dma_data),
    .IRQ(irq), .WORD_WIDTH_SEL(word_sel), .LANE_ORDER_SEL(lane_sel),
    .WIDE_ADDR_SEL(wide_sel), .ADDR_LOW(addr_low), .ADDR_HIGH(addr_high), .DATA_LANES(lanes));

  imdc_host i_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic final_report();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    logic ok;
    i_host.xfer(wr, a, wd, rd, err, ok);
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("wrong value at %0t: bus gave no answer", $time);
      final_report();
    end
  endtask : bus

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    tick(2);
    chk(wide_sel, 1'b1);
    chk(irq, 1'b0);
    bus(1'b0, A_CFG, 32'h0000_0000);
    chk(rd, 32'h0000_0004);
    bus(1'b0, A_MASK, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
  endtask : t_reset

  task automatic t_cfg();
    logic [7:0] c;
    for (int k = 0; k < 8; k++) begin
      c = k[7:0];
      bus(1'b1, A_CFG, {24'h00_0000, c});
      tick(3);
      chk(word_sel, c[0]);
      chk(lane_sel, c[1]);
      chk(wide_sel, c[2]);
      chk(addr_low, c[0] ? 16'h1234 : 16'h1235);
      chk(lanes, (c[0] & c[1]) ? 16'h5aa5 : 16'ha55a);
      chk(lanes[7:0], (c[0] & c[1]) ? 8'ha5 : 8'h5a);
      chk(addr_low[0], c[0] ? 1'b0 : 1'b1);
      chk(addr_high, c[2] ? 16'hbeef : 16'h0000);
      bus(1'b0, A_CFG, 32'h0000_0000);
      chk(rd, {24'h00_0000, c});
    end
  endtask : t_cfg

  task automatic t_mask();
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, A_MASK, {24'h00_0000, 8'h01 << i});
      flags <= ~(8'h01 << i);
      tick(2);
      chk(irq, 1'b0);
      flags <= 8'h01 << i;
      tick(2);
      chk(irq, i < 7);
    end
  endtask : t_mask

  task automatic t_hold();
    bus(1'b1, A_MASK, 32'h0000_0041);
    flags <= 8'h41;
    tick(2);
    chk(irq, 1'b1);
    flags <= 8'h40;
    tick(2);
    chk(irq, 1'b1);
    bus(1'b0, imdc_pkg::ADDR_CAUSE_FLAGS, 32'h0000_0000);
    chk(rd, 32'h0000_0140);
    flags <= 8'h00;
    tick(2);
    chk(irq, 1'b0);
  endtask : t_hold

  task automatic t_bad();
    bus(1'b1, 12'h040, 32'h0000_00ff);
    chk(err, 1'b1);
    bus(1'b0, A_MASK, 32'h0000_0000);
    chk(rd, 32'h0000_0041);
    chk(err, 1'b0);
    bus(1'b0, 12'h040, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(err, 1'b1);
    bus(1'b0, imdc_pkg::ADDR_DMA_VIEW, 32'h0000_0000);
    chk(rd, 32'hbeef_1234);
  endtask : t_bad

  task automatic t_rerst();
    bus(1'b1, A_CFG, 32'h0000_0000);
    flags <= 8'h41;
    tick(2);
    chk(wide_sel, 1'b0);
    chk(irq, 1'b1);
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    tick(2);
    chk(wide_sel, 1'b1);
    chk(irq, 1'b0);
    bus(1'b0, A_MASK, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
  endtask : t_rerst

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_cfg();
    t_mask();
    t_hold();
    t_bad();
    t_rerst();
    final_report();
  end
endmodule : tb_top
`default_nettype wire
